/* File: xbus_defs.vh */
// constants for the external expansion bus pin engine
// assumes a 100 MHz core clock and a five-state machine cycle
`ifndef XBUS_DEFS_VH
`define XBUS_DEFS_VH

// machine cycle slots, in core clocks
`define XBUS_SLOT_ADDR   3'h0
`define XBUS_SLOT_ALE_LO 3'h1
`define XBUS_SLOT_STRB   3'h2
`define XBUS_SLOT_SAMP   3'h3
`define XBUS_SLOT_LAST   3'h4

// command codes from the core
`define XBUS_CMD_IDLE    3'h0
`define XBUS_CMD_FETCH   3'h1
`define XBUS_CMD_READ    3'h2
`define XBUS_CMD_WRITE   3'h3
`define XBUS_CMD_OUTP    3'h4
`define XBUS_CMD_EXP     3'h5

// reset values
`define XBUS_BYTE_ZERO   8'h00
`define XBUS_BYTE_ONES   8'hff
`define XBUS_NIB_ZERO    4'h0
`define XBUS_NIB_ONES    4'hf
`define XBUS_CNT_ZERO    8'h00
`define XBUS_CNT_ONE     8'h01

`endif

/* File: xbus_pins.v */
// external expansion bus pin engine: strobes, shared bus, port 2 nibbles,
// port 1, expander strobe and test input one.
// assumes a core issues one command per machine cycle on cmd_i, held until
// cmd_ack_o; pins are sampled synchronously to clk_i.
//
// Operation
// [RULE1] external fetch select forces every fetch to external program memory
// [RULE2] read strobe goes low during bus reads
// [RULE3] program fetch strobe low only for fetches from external memory
// [RULE4] store strobe goes low during bus writes
// [RULE5] address capture strobe pulses once every machine cycle
// [RULE6] address valid on shared bus at falling edge of capture strobe
// [RULE7] shared bus written or read synchronously under store or read strobe
// [RULE8] shared bus can hold written output value statically latched
// [RULE9] low eight program address bits driven on bus during external fetch
// [RULE10] instruction byte taken from bus while program fetch strobe low
// [RULE11] data access: address under capture strobe, then read or store data
// [RULE12] upper four program address bits on port two low nibble
// [RULE13] port two low nibble also carries expander command and data nibbles
// [RULE14] expander strobe times nibble transfers with the expander
// [RULE15] port one and port two high nibble are quasi-bidirectional
// [RULE16] jump instructions sample test input one high or low
// [RULE17] after start count, test input one is the counter event input
// [RULE18] shared bus floats during reset unless external fetch select high; code floats it during reset whatever the select level
// [RULE19] external fetch select raised only while reset is held low
// [RULE20] read, store and program fetch strobes never low together
`timescale 1ns/1ps
`include "xbus_defs.vh"

module xbus_pins (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // core side
  input  wire [2:0]  cmd_i,
  input  wire [11:0] addr_i,
  input  wire [7:0]  wdata_i,
  input  wire [3:0]  exp_nib_i,
  input  wire        int_rom_hit_i,
  input  wire [7:0]  port_one_wr_i,
  input  wire        port_one_we_i,
  input  wire [3:0]  port_two_high_wr_i,
  input  wire        port_two_high_we_i,
  input  wire        start_count_instruction_i,
  input  wire        stop_count_i,
  output reg         cmd_ack_o,
  output reg  [7:0]  rdata_o,
  output reg         rdata_ext_o,
  output reg  [3:0]  exp_rdata_o,
  output reg         cycle_start_o,
  output reg         test_one_level_o,
  output reg  [7:0]  event_count_o,
  output reg  [7:0]  port_one_in_o,
  output reg  [3:0]  port_two_high_in_o,
  // pins
  input  wire        external_fetch_select_i,
  output reg         address_capture_strobe_o,
  output reg         read_strobe_n_o,
  output reg         store_strobe_n_o,
  output reg         program_fetch_strobe_n_o,
  output reg         expander_strobe_o,
  input  wire [7:0]  shared_bus_lines_i,
  output reg  [7:0]  shared_bus_lines_o,
  output reg  [7:0]  shared_bus_lines_oe_o,
  input  wire [3:0]  port_two_low_nibble_i,
  output reg  [3:0]  port_two_low_nibble_o,
  output reg  [3:0]  port_two_low_nibble_oe_o,
  input  wire [3:0]  port_two_high_nibble_i,
  output reg  [3:0]  port_two_high_nibble_o,
  output reg  [3:0]  port_two_high_nibble_oe_o,
  input  wire [7:0]  port_one_lines_i,
  output reg  [7:0]  port_one_lines_o,
  output reg  [7:0]  port_one_lines_oe_o,
  input  wire        test_input_one_i
);

  reg  [2:0] slot_q;
  reg  [2:0] op_q;
  reg        ext_sel_q;
  reg  [7:0] bus_latch_q;
  // set by a bus output command; keeps the latched byte on the pins
  reg        bus_hold_q;
  reg        count_on_q;
  reg        t1_prev_q;
  reg  [7:0] p1_q;
  reg  [3:0] p2h_q;
  reg  [7:0] p1_prev_q;
  reg  [3:0] p2h_prev_q;

  // fetch is external when select pin is high or address misses internal rom
  wire fetch_ext = ext_sel_q | ~int_rom_hit_i; // RULE1

  // quasi-bidirectional drive: strong pulse on a rising write, then weak high
  // modelled as oe only for a low bit or the first cycle of a 0->1 change
  function [7:0] quasi_oe;
    input [7:0] val;
    input [7:0] prev;
    begin
      quasi_oe = ~val | (val & ~prev);
    end
  endfunction

  // external fetch select sampled at every machine cycle start, not under async reset
  // limitation: a select change is only seen at the next cycle start (slot 0)
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sel_q <= 1'b0;
    end else if (slot_q == `XBUS_SLOT_ADDR && op_q == `XBUS_CMD_IDLE) begin
      ext_sel_q <= external_fetch_select_i; // RULE19
    end
  end

  // machine cycle slot counter and command capture
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q        <= `XBUS_SLOT_ADDR;
      op_q          <= `XBUS_CMD_IDLE;
      cmd_ack_o     <= 1'b0;
      cycle_start_o <= 1'b0;
    end else begin
      cmd_ack_o     <= (slot_q == `XBUS_SLOT_LAST) && (op_q != `XBUS_CMD_IDLE);
      cycle_start_o <= (slot_q == `XBUS_SLOT_LAST);
      if (slot_q == `XBUS_SLOT_LAST) begin
        slot_q <= `XBUS_SLOT_ADDR;
        op_q   <= `XBUS_CMD_IDLE;
      end else begin
        slot_q <= slot_q + 3'h1;
        // a command still held during the ack pulse is refused, not run twice
        if (slot_q == `XBUS_SLOT_ADDR && !cmd_ack_o) begin
          op_q <= cmd_i;
        end
      end
    end
  end

  // strobes: capture strobe high in slot 0 only, one strobe per cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      address_capture_strobe_o <= 1'b0;
      read_strobe_n_o          <= 1'b1;
      store_strobe_n_o         <= 1'b1;
      program_fetch_strobe_n_o <= 1'b1;
      expander_strobe_o        <= 1'b1;
    end else begin
      address_capture_strobe_o <= (slot_q == `XBUS_SLOT_LAST); // RULE5
      read_strobe_n_o  <= 1'b1;
      store_strobe_n_o <= 1'b1;
      program_fetch_strobe_n_o <= 1'b1;
      expander_strobe_o <= 1'b1;
      if (slot_q == `XBUS_SLOT_ALE_LO || slot_q == `XBUS_SLOT_STRB) begin
        // op_q selects at most one strobe, so they never overlap
        case (op_q)
          // internal fetches keep the fetch strobe high so external rom stays idle
          `XBUS_CMD_FETCH: program_fetch_strobe_n_o <= ~fetch_ext; // RULE3 RULE20
          `XBUS_CMD_READ:  read_strobe_n_o  <= 1'b0; // RULE2 RULE11
          `XBUS_CMD_WRITE: store_strobe_n_o <= 1'b0; // RULE4 RULE11
          `XBUS_CMD_EXP:   expander_strobe_o <= 1'b0; // RULE14
          default:         expander_strobe_o <= 1'b1;
        endcase
      end
    end
  end

  // shared bus drive: address while capture strobe high, data on writes
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shared_bus_lines_o    <= `XBUS_BYTE_ZERO;
      shared_bus_lines_oe_o <= `XBUS_BYTE_ZERO; // RULE18
      bus_latch_q           <= `XBUS_BYTE_ZERO;
      bus_hold_q            <= 1'b0;
    end else begin
      if (slot_q == `XBUS_SLOT_LAST) begin
        // next cycle's address set up before the capture strobe falls
        if (cmd_i == `XBUS_CMD_FETCH && fetch_ext) begin
          shared_bus_lines_o    <= addr_i[7:0]; // RULE9 RULE6
          shared_bus_lines_oe_o <= `XBUS_BYTE_ONES;
        end else if (cmd_i == `XBUS_CMD_READ || cmd_i == `XBUS_CMD_WRITE) begin
          shared_bus_lines_o    <= addr_i[7:0]; // RULE11 RULE6
          shared_bus_lines_oe_o <= `XBUS_BYTE_ONES;
        end else begin
          // released unless the output latch or external select owns the bus
          shared_bus_lines_o    <= bus_latch_q; // RULE8
          shared_bus_lines_oe_o <= (ext_sel_q || bus_hold_q) ? `XBUS_BYTE_ONES : `XBUS_BYTE_ZERO;
        end
      end else if (slot_q == `XBUS_SLOT_ALE_LO) begin
        // op_q is only valid from slot 1 on; slot 0 still shows the idle code
        // release for reads, drive data for stores, else static latch
        case (op_q)
          `XBUS_CMD_WRITE: begin
            shared_bus_lines_o    <= wdata_i; // RULE7
            shared_bus_lines_oe_o <= `XBUS_BYTE_ONES;
          end
          `XBUS_CMD_FETCH, `XBUS_CMD_READ: begin
            shared_bus_lines_oe_o <= `XBUS_BYTE_ZERO; // RULE7
          end
          `XBUS_CMD_OUTP: begin
            bus_latch_q           <= wdata_i; // RULE8
            bus_hold_q            <= 1'b1; // RULE8
            shared_bus_lines_o    <= wdata_i;
            shared_bus_lines_oe_o <= `XBUS_BYTE_ONES;
          end
          default: begin
            shared_bus_lines_o <= shared_bus_lines_o;
          end
        endcase
      end
    end
  end

  // read data sampled at the end of the strobe window
  // the strobe is still low at this edge, so the partner is still driving
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o     <= `XBUS_BYTE_ZERO;
      rdata_ext_o <= 1'b0;
      exp_rdata_o <= `XBUS_NIB_ZERO;
    end else if (slot_q == `XBUS_SLOT_SAMP) begin
      if ((op_q == `XBUS_CMD_FETCH && fetch_ext) || op_q == `XBUS_CMD_READ) begin
        rdata_o     <= shared_bus_lines_i; // RULE10 RULE7
        rdata_ext_o <= 1'b1;
      end else begin
        rdata_ext_o <= 1'b0;
      end
      if (op_q == `XBUS_CMD_EXP) begin
        exp_rdata_o <= port_two_low_nibble_i; // RULE13
      end
    end
  end

  // port two low nibble: upper fetch address, or expander nibble
  // trade-off: command nibble shown before the strobe, data nibble during it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_two_low_nibble_o    <= `XBUS_NIB_ZERO;
      port_two_low_nibble_oe_o <= `XBUS_NIB_ZERO;
    end else if (slot_q == `XBUS_SLOT_LAST) begin
      if (cmd_i == `XBUS_CMD_FETCH && fetch_ext) begin
        port_two_low_nibble_o    <= addr_i[11:8]; // RULE12
        port_two_low_nibble_oe_o <= `XBUS_NIB_ONES;
      end else if (cmd_i == `XBUS_CMD_EXP) begin
        port_two_low_nibble_o    <= exp_nib_i; // RULE13
        port_two_low_nibble_oe_o <= `XBUS_NIB_ONES;
      end else begin
        port_two_low_nibble_oe_o <= `XBUS_NIB_ZERO;
      end
    end else if (slot_q == `XBUS_SLOT_ALE_LO && op_q == `XBUS_CMD_EXP && wdata_i[0]) begin
      // command nibble first, then data nibble for expander writes
      port_two_low_nibble_o <= wdata_i[7:4]; // RULE13
    end else if (slot_q == `XBUS_SLOT_ALE_LO && op_q == `XBUS_CMD_EXP) begin
      port_two_low_nibble_oe_o <= `XBUS_NIB_ZERO;
    end
  end

  // high nibble reuses the byte-wide drive rule with the spare bits held high
  wire [7:0] p2h_oe_w = quasi_oe({`XBUS_NIB_ONES, p2h_q}, {`XBUS_NIB_ONES, p2h_prev_q});

  // quasi-bidirectional ports; inputs read back from the pins
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_q      <= `XBUS_BYTE_ONES;
      p2h_q     <= `XBUS_NIB_ONES;
      p1_prev_q <= `XBUS_BYTE_ONES;
      p2h_prev_q <= `XBUS_NIB_ONES;
      port_one_lines_o    <= `XBUS_BYTE_ONES;
      port_one_lines_oe_o <= `XBUS_BYTE_ZERO;
      port_two_high_nibble_o    <= `XBUS_NIB_ONES;
      port_two_high_nibble_oe_o <= `XBUS_NIB_ZERO;
      port_one_in_o       <= `XBUS_BYTE_ZERO;
      port_two_high_in_o  <= `XBUS_NIB_ZERO;
    end else begin
      if (port_one_we_i) p1_q <= port_one_wr_i;
      if (port_two_high_we_i) p2h_q <= port_two_high_wr_i;
      p1_prev_q  <= p1_q;
      p2h_prev_q <= p2h_q;
      port_one_lines_o    <= p1_q;
      port_one_lines_oe_o <= quasi_oe(p1_q, p1_prev_q); // RULE15
      port_two_high_nibble_o    <= p2h_q;
      port_two_high_nibble_oe_o <= p2h_oe_w[3:0]; // RULE15
      port_one_in_o      <= port_one_lines_i;
      port_two_high_in_o <= port_two_high_nibble_i;
    end
  end

  // test input one: level for jumps, falling edges counted once started
  // pin idles high and prev resets low, so no false edge follows reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_one_level_o <= 1'b0;
      t1_prev_q        <= 1'b0;
      count_on_q       <= 1'b0;
      event_count_o    <= `XBUS_CNT_ZERO;
    end else begin
      test_one_level_o <= test_input_one_i; // RULE16
      t1_prev_q        <= test_input_one_i;
      if (start_count_instruction_i) begin
        count_on_q <= 1'b1; // RULE17
      end else if (stop_count_i) begin
        count_on_q <= 1'b0;
      end
      if (count_on_q && t1_prev_q && !test_input_one_i) begin
        event_count_o <= event_count_o + `XBUS_CNT_ONE; // RULE17
      end
    end
  end

endmodule // xbus_pins

/* File: xbus_asserts.sv */
// checker for the expansion bus pin engine
// assumes it is bound to xbus_pins and sees only its ports
`timescale 1ns/1ps
module xbus_asserts (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire [11:0] addr_i,
  input wire        address_capture_strobe_o,
  input wire        read_strobe_n_o,
  input wire        store_strobe_n_o,
  input wire        program_fetch_strobe_n_o,
  input wire [7:0]  shared_bus_lines_o,
  input wire [7:0]  shared_bus_lines_oe_o,
  input wire [3:0]  port_two_low_nibble_o,
  input wire [3:0]  port_two_low_nibble_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // address phase, then the strobe of the transfer
  sequence s_addr;
    address_capture_strobe_o ##1 !address_capture_strobe_o;
  endsequence
  sequence s_rd;
    s_addr ##1 !read_strobe_n_o;
  endsequence
  sequence s_pf;
    s_addr ##1 !program_fetch_strobe_n_o;
  endsequence
  AST_ALE_ONCE: assert property ($rose(address_capture_strobe_o) |=>
    !address_capture_strobe_o [*4] ##1 address_capture_strobe_o) else $error("capture strobe period");
  AST_ONE_STRB: assert property ($onehot0({~read_strobe_n_o, ~store_strobe_n_o,
    ~program_fetch_strobe_n_o})) else $error("strobes overlap");
  AST_RD_FREE: assert property (!read_strobe_n_o |-> shared_bus_lines_oe_o == 8'h00)
    else $error("bus driven in read");
  AST_WR_DRV: assert property (!store_strobe_n_o |-> shared_bus_lines_oe_o == 8'hff)
    else $error("bus not driven in write");
  AST_PF_FREE: assert property (!program_fetch_strobe_n_o |-> shared_bus_lines_oe_o == 8'h00)
    else $error("bus driven in fetch");
  AST_RD_ADDR: assert property (s_rd |-> $past(shared_bus_lines_oe_o, 2) == 8'hff)
    else $error("no address before read");
  AST_PF_ADDR: assert property (s_pf |-> $past(shared_bus_lines_o, 2) == addr_i[7:0])
    else $error("fetch address wrong");
  AST_P2_ADDR: assert property (!program_fetch_strobe_n_o |-> port_two_low_nibble_oe_o == 4'hf
    && port_two_low_nibble_o == addr_i[11:8]) else $error("upper address wrong");
  AST_RD_LEN: assert property ($fell(read_strobe_n_o) |=> !read_strobe_n_o ##1 read_strobe_n_o)
    else $error("read strobe length");
endmodule // xbus_asserts

bind xbus_pins xbus_asserts xbus_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .address_capture_strobe_o(address_capture_strobe_o), .read_strobe_n_o(read_strobe_n_o),
  .store_strobe_n_o(store_strobe_n_o), .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
  .shared_bus_lines_o(shared_bus_lines_o), .shared_bus_lines_oe_o(shared_bus_lines_oe_o),
  .port_two_low_nibble_o(port_two_low_nibble_o), .port_two_low_nibble_oe_o(port_two_low_nibble_oe_o));

/* File: xbus_mem_model.sv */
// external program rom, data ram and expander data capture
// assumes bus_i is the resolved pin level of the shared bus
`timescale 1ns/1ps
module xbus_mem_model (
  input  wire       clk_i,
  input  wire       ale_i,
  input  wire       rd_n_i,
  input  wire       wr_n_i,
  input  wire       pf_n_i,
  input  wire       exp_i,
  input  wire [7:0] bus_i,
  input  wire [3:0] p2_i,
  output wire [7:0] drv_o,
  output reg  [3:0] exp_dat_o
);
  reg [7:0] mem [0:255];
  reg [7:0] adr_q;
  reg [7:0] last_q;
  integer   k;
  // one array serves program and data space
  initial begin
    for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'h5a;
    adr_q = 8'h00;
    last_q = 8'h00;
    exp_dat_o = 4'h0;
  end
  always @(negedge ale_i) adr_q <= bus_i;
  // released bus shows the inverse of its last level
  assign drv_o = (!rd_n_i || !pf_n_i) ? mem[adr_q] : ~last_q;
  // sample on the clock, not on the strobe edge, to dodge release races
  always @(posedge clk_i) begin
    last_q <= bus_i;
    if (!wr_n_i) mem[adr_q] <= bus_i;
    if (!exp_i) exp_dat_o <= p2_i;
  end
endmodule // xbus_mem_model

/* File: tb_top.sv */
// self-checking bench for the expansion bus pin engine
// assumes xbus_pins, xbus_mem_model and the bound checker
`timescale 1ns/1ps
`include "xbus_defs.vh"
`define CHK(nm, ex, ac) begin \
  comparisons = comparisons + 1; \
  if ((ac) !== (ex)) begin \
    fails = fails + 1; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); \
  end \
end
module tb_top;
  reg        clk_i, rst_n_i, int_rom_hit_i, port_one_we_i, port_two_high_we_i, stop_count_i;
  reg        start_count_instruction_i, external_fetch_select_i, test_input_one_i;
  reg [2:0]  cmd_i;
  reg [11:0] addr_i;
  reg [7:0]  wdata_i, port_one_wr_i, p1_pull;
  reg [3:0]  exp_nib_i, port_two_high_wr_i;
  wire       cmd_ack_o, rdata_ext_o, cycle_start_o, test_one_level_o, address_capture_strobe_o;
  wire       read_strobe_n_o, store_strobe_n_o, program_fetch_strobe_n_o, expander_strobe_o;
  wire [7:0] rdata_o, event_count_o, port_one_in_o, shared_bus_lines_i, shared_bus_lines_o, drv;
  wire [7:0] shared_bus_lines_oe_o, port_one_lines_i, port_one_lines_o, port_one_lines_oe_o;
  wire [3:0] exp_rdata_o, port_two_high_in_o, port_two_low_nibble_i, port_two_low_nibble_o, exp_dat;
  wire [3:0] port_two_low_nibble_oe_o, port_two_high_nibble_i, port_two_high_nibble_o;
  wire [3:0] port_two_high_nibble_oe_o;
  integer    fails, comparisons, pf_cnt, exp_cnt, n, c0;
  // pin levels: quasi lines pull high, port one can be pulled low
  assign shared_bus_lines_i = (shared_bus_lines_oe_o & shared_bus_lines_o) | (~shared_bus_lines_oe_o & drv);
  assign port_two_low_nibble_i = ~port_two_low_nibble_oe_o | port_two_low_nibble_o;
  assign port_two_high_nibble_i = ~port_two_high_nibble_oe_o | port_two_high_nibble_o;
  assign port_one_lines_i = (~port_one_lines_oe_o | port_one_lines_o) & p1_pull;
  xbus_pins xbus_pins_inst (.*);
  xbus_mem_model xbus_mem_model_inst (.clk_i(clk_i), .ale_i(address_capture_strobe_o),
    .rd_n_i(read_strobe_n_o), .wr_n_i(store_strobe_n_o), .pf_n_i(program_fetch_strobe_n_o),
    .exp_i(expander_strobe_o), .bus_i(shared_bus_lines_i), .p2_i(port_two_low_nibble_i),
    .drv_o(drv), .exp_dat_o(exp_dat));
  always @(negedge program_fetch_strobe_n_o) pf_cnt = pf_cnt + 1;
  always @(negedge expander_strobe_o) exp_cnt = exp_cnt + 1;
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task tick;
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // one command, held until acknowledged, with a bounded wait
  task do_cmd(input [2:0] c, input [11:0] a, input [7:0] d);
    begin
      tick;
      cmd_i = c;
      addr_i = a;
      wdata_i = d;
      tick;
      for (n = 0; n < 30 && cmd_ack_o !== 1'b1; n = n + 1) tick;
      if (cmd_ack_o !== 1'b1) begin
        fails = fails + 1;
        test_done;
      end
      cmd_i = `XBUS_CMD_IDLE;
    end
  endtask
  task t_reset;
    begin
      repeat (10) tick;
      `CHK("oe", 8'h00, shared_bus_lines_oe_o)
      `CHK("strb", 4'he, {read_strobe_n_o, store_strobe_n_o, program_fetch_strobe_n_o, address_capture_strobe_o})
      rst_n_i = 1'b1;
      $display("t_reset done");
    end
  endtask
  task t_fetch;
    begin
      do_cmd(`XBUS_CMD_FETCH, 12'h3a7, 8'h00);
      `CHK("fdat", 8'hfd, rdata_o)
      `CHK("fext", 1'b1, rdata_ext_o)
      c0 = pf_cnt;
      int_rom_hit_i = 1'b1;
      do_cmd(`XBUS_CMD_FETCH, 12'h155, 8'h00);
      `CHK("ipf", c0, pf_cnt)
      `CHK("iext", 1'b0, rdata_ext_o)
      $display("t_fetch done");
    end
  endtask
  task t_wr_rd;
    begin
      do_cmd(`XBUS_CMD_WRITE, 12'h033, 8'hc4);
      do_cmd(`XBUS_CMD_READ, 12'h033, 8'h00);
      `CHK("rdat", 8'hc4, rdata_o)
      `CHK("rext", 1'b1, rdata_ext_o)
      $display("t_wr_rd done");
    end
  endtask
  task t_outp;
    begin
      do_cmd(`XBUS_CMD_OUTP, 12'h000, 8'h96);
      `CHK("cst", 1'b1, cycle_start_o)
      repeat (3) tick;
      `CHK("loe", 8'hff, shared_bus_lines_oe_o)
      `CHK("lval", 8'h96, shared_bus_lines_o)
      $display("t_outp done");
    end
  endtask
  task t_exp;
    begin
      c0 = exp_cnt;
      exp_nib_i = 4'h2;
      do_cmd(`XBUS_CMD_EXP, 12'h000, 8'ha1);
      `CHK("xstb", c0 + 1, exp_cnt)
      `CHK("xdat", 4'ha, exp_dat)
      `CHK("xrd", 4'ha, exp_rdata_o)
      $display("t_exp done");
    end
  endtask
  task t_ports;
    begin
      p1_pull = 8'hc3;
      port_one_wr_i = 8'hff;
      port_two_high_wr_i = 4'h6;
      port_one_we_i = 1'b1;
      port_two_high_we_i = 1'b1;
      tick;
      port_one_we_i = 1'b0;
      port_two_high_we_i = 1'b0;
      repeat (4) tick;
      `CHK("p1in", 8'hc3, port_one_in_o)
      `CHK("p1oe", 8'h00, port_one_lines_oe_o)
      `CHK("p2in", 4'h6, port_two_high_in_o)
      `CHK("p2oe", 4'h9, port_two_high_nibble_oe_o)
      $display("t_ports done");
    end
  endtask
  task t_test_one;
    begin
      test_input_one_i = 1'b0;
      repeat (3) tick;
      `CHK("t1lo", 1'b0, test_one_level_o)
      test_input_one_i = 1'b1;
      repeat (3) tick;
      `CHK("t1hi", 1'b1, test_one_level_o)
      start_count_instruction_i = 1'b1;
      tick;
      start_count_instruction_i = 1'b0;
      for (n = 0; n < 6; n = n + 1) begin
        test_input_one_i = ~test_input_one_i;
        repeat (2) tick;
      end
      `CHK("cnt", 8'h03, event_count_o)
      stop_count_i = 1'b1;
      tick;
      stop_count_i = 1'b0;
      test_input_one_i = 1'b0;
      repeat (3) tick;
      `CHK("stop", 8'h03, event_count_o)
      $display("t_test_one done");
    end
  endtask
  task t_ext_sel;
    begin
      rst_n_i = 1'b0;
      external_fetch_select_i = 1'b1;
      repeat (10) tick;
      rst_n_i = 1'b1;
      repeat (12) tick;
      c0 = pf_cnt;
      do_cmd(`XBUS_CMD_FETCH, 12'h2c1, 8'h00);
      `CHK("epf", c0 + 1, pf_cnt)
      `CHK("edat", 8'h9b, rdata_o)
      $display("t_ext_sel done");
    end
  endtask
  initial begin
    {rst_n_i, int_rom_hit_i, port_one_we_i, port_two_high_we_i, stop_count_i} = 5'h00;
    {start_count_instruction_i, external_fetch_select_i, test_input_one_i} = 3'h1;
    {cmd_i, addr_i, wdata_i, port_one_wr_i, exp_nib_i, port_two_high_wr_i} = 39'h0;
    p1_pull = 8'hff;
    {fails, comparisons, pf_cnt, exp_cnt} = 128'h0;
    t_reset;
    t_fetch;
    int_rom_hit_i = 1'b0;
    t_wr_rd;
    t_outp;
    t_exp;
    t_ports;
    t_test_one;
    int_rom_hit_i = 1'b1;
    t_ext_sel;
    test_done;
  end
endmodule // tb_top
